// file: rtl/pic_defs.svh
// Address map, field positions, vectors and timing counts of the interrupt controller
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH

// Special-function byte addresses
`define PIC_ADDR_W 8
`define PIC_ADR_EN_C 8'h2a
`define PIC_ADR_LT_C 8'h2b
`define PIC_ADR_EN_BL 8'h2c
`define PIC_ADR_EN_BH 8'h2d
`define PIC_ADR_LT_BL 8'h2e
`define PIC_ADR_LT_BH 8'h2f
`define PIC_ADR_EN_AL 8'h3a
`define PIC_ADR_EN_AH 8'h3b
`define PIC_ADR_LT_AL 8'h3c
`define PIC_ADR_LT_AH 8'h3d

// Priority numbers and field positions
`define PIC_NPRIO 39
`define PIC_PRIO_W 6
`define PIC_PRIO_SWI 6'h01
`define PIC_PRIO_WDT 6'h02
`define PIC_PRIO_EXT0 6'h03
`define PIC_FIRST_LATCH 2
`define PIC_FIRST_ENABLE 3
`define PIC_BANK_C_BASE 32
`define PIC_MASTER_BIT 0

// Vector table
`define PIC_VEC_W 20
`define PIC_VEC_TOP 20'hf_fffc
`define PIC_VEC_HIGH 20'hf_ff3c

// Acceptance timing: machine cycle length in clocks and sequence length
`define PIC_MC_CLKS 4
`define PIC_ACC_MC 12
`define PIC_NEST_W 2

`endif

// file: rtl/pic_pkg.sv
// Types shared by the interrupt controller modules
package pic_pkg;

  // Register access from the CPU core's special-function space
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pic_sfr_s;

  // Instruction events and acceptance handshake from the CPU core
  typedef struct packed {
    logic boundary;
    logic accept;
    logic irq_on;
    logic irq_off;
    logic ret_mask;
    logic ret_pseudo;
    logic popped_master;
  } pic_cpu_s;

  typedef enum logic [1:0] {
    PIC_IDLE,
    PIC_OFFER,
    PIC_SEQ
  } pic_state_e;

endpackage

// file: rtl/pic_prio.sv
// Fixed-priority selector with vector lookup
`timescale 1ns/1ps
`include "pic_defs.svh"

module pic_prio
  import pic_pkg::*;
#(
  parameter int NPRIO = `PIC_NPRIO
) (
  // Acceptable requests, bit index is the priority number
  input wire logic [NPRIO-1:0] acceptable,
  // Winner
  output logic found,
  output logic [`PIC_PRIO_W-1:0] prio,
  output logic [`PIC_VEC_W-1:0] vector
);

  logic [`PIC_VEC_W-1:0] off;

  always_comb begin
    found = 1'b0;
    prio = '0;
    for (int i = NPRIO - 1; i >= 0; i--) begin
      if (acceptable[i]) begin
        found = 1'b1;
        prio = `PIC_PRIO_W'(i);
      end
    end
  end

  // each priority has its own vector
  always_comb begin
    if (prio < `PIC_PRIO_W'(`PIC_BANK_C_BASE)) begin
      off = `PIC_VEC_W'({prio, 2'b00});
      vector = `PIC_VEC_TOP - off;
    end else begin
      off = `PIC_VEC_W'({prio - `PIC_PRIO_W'(`PIC_BANK_C_BASE), 2'b00});
      vector = `PIC_VEC_HIGH - off;
    end
  end

endmodule

// file: rtl/pic_nest.sv
// Interrupt nesting counter
`timescale 1ns/1ps
`include "pic_defs.svh"

module pic_nest
  import pic_pkg::*;
#(
  parameter int W = `PIC_NEST_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Events
  input wire logic up,
  input wire logic down,
  // Depth
  output logic [W-1:0] count_reg
);

  // up on acceptance, down on return
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
    end else if (up && !down) begin
      // Saturates so deep nesting still reads as "level 3 or more"
      if (count_reg != '1) begin
        count_reg <= count_reg + W'(1);
      end
    end else if (down && !up) begin
      // Underflow is not detected; software must keep returns balanced
      count_reg <= count_reg - W'(1);
    end
  end

endmodule

// file: rtl/pic_top.sv
// Prioritized nestable interrupt controller for an 8-bit CPU core
// Function
// - 38 request priorities, two pseudo non-maskable, rest maskable
// - any priority may nest once re-enabled
// - fixed order, lower priority number wins
// - no ordering between software and undefined sources, which share one priority
// - own vector per priority, fixed table
// - latch set on request, maskable latch asks only if enabled
// - master flag gates all maskable sources
// - external input 0 needs extra pin enable
// - pseudo non-maskable ignore all enable flags
// - software and undefined sources have no latch
// - accepted source latch cleared on acceptance
// - reset clears every request latch
// - software clears latches by zero, never sets
// - latch bytes at five special-function addresses
// - enable bytes readable and writable, unused bits read as zero
// - master flag saved then cleared on acceptance
// - maskable return sets master flag
// - pseudo non-maskable return restores saved flag
// - master flag at bit0, set/clear instructions
// - watchdog requests only when output select cleared
// - reset clears all source enable flags
// - acceptance sequence lasts twelve machine cycles
// - nesting counter counts acceptances and returns
`timescale 1ns/1ps
`include "pic_defs.svh"

module pic_top
  import pic_pkg::*;
#(
  parameter int NPRIO = `PIC_NPRIO,
  parameter int MC_CLKS = `PIC_MC_CLKS,
  parameter int ACC_MC = `PIC_ACC_MC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Special-function register access
  input wire pic_sfr_s sfr,
  output logic [7:0] sfr_rdata_reg,
  // CPU core events and handshake
  input wire pic_cpu_s cpu,
  input wire logic software_irq,
  input wire logic undef_irq,
  // Request sources, one-cycle pulses, bit index is the priority number
  input wire logic [NPRIO-1:0] src_req,
  input wire logic ext0_input_enable,
  input wire logic watchdog_output_select,
  // Offer to the CPU core
  output logic irq_pending_reg,
  output logic [`PIC_VEC_W-1:0] irq_vector_reg,
  output logic [`PIC_PRIO_W-1:0] irq_prio_reg,
  output logic seq_busy_reg,
  // Flags
  output logic master_enable_flag,
  output logic master_push_reg,
  output logic [`PIC_NEST_W-1:0] nesting_counter
);

  localparam int MCW = $clog2(MC_CLKS + 1);
  localparam int SQW = $clog2(ACC_MC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [NPRIO-1:0] request_latch;
  logic [NPRIO-1:0] source_enable_flag;
  logic [NPRIO-1:0] sw_clear;
  logic [NPRIO-1:0] en_wr_mask;
  logic [NPRIO-1:0] en_wr_val;
  logic [NPRIO-1:0] acceptable;
  logic [NPRIO-1:0] pending;
  logic master_reg;
  logic master_next;
  logic sel_found;
  logic [`PIC_PRIO_W-1:0] sel_prio;
  logic [`PIC_VEC_W-1:0] sel_vector;
  logic take;
  logic [MCW-1:0] mc_cnt_reg;
  logic mc_tick;
  logic [SQW-1:0] seq_cnt_reg;
  logic [7:0] rd_next;
  pic_state_e state_reg;

  assign master_enable_flag = master_reg;
  // Acceptance only counts while an offer is standing
  assign take = cpu.accept && (state_reg == PIC_OFFER);

  ////////////////////////////////////////////////////////////////////////////
  // Request latches

  // priorities 0 and 1 carry no latch
  assign request_latch[`PIC_FIRST_LATCH-1:0] = '0;

  generate
    for (genvar i = `PIC_FIRST_LATCH; i < NPRIO; i++) begin : g_latch
      logic set;
      logic clr;
      logic bit_reg;
      // watchdog only raises a request with output select cleared
      if (i == `PIC_PRIO_WDT) begin : g_wdt
        assign set = src_req[i] && !watchdog_output_select;
      end else begin : g_src
        assign set = src_req[i];
      end
      assign clr = (take && irq_prio_reg == `PIC_PRIO_W'(i)) || sw_clear[i];
      // reset clears; set wins over clear; set on request
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          bit_reg <= 1'b0;
        end else if (set) begin
          bit_reg <= 1'b1;
        end else if (clr) begin
          bit_reg <= 1'b0;
        end
      end
      assign request_latch[i] = bit_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register writes decoded into per-bit strobes

  // a written zero clears, a written one does nothing
  always_comb begin
    sw_clear = '0;
    if (sfr.wr) begin
      if (sfr.addr == `PIC_ADR_LT_AL) begin
        sw_clear[7:0] = ~sfr.wdata;
      end else if (sfr.addr == `PIC_ADR_LT_AH) begin
        sw_clear[15:8] = ~sfr.wdata;
      end else if (sfr.addr == `PIC_ADR_LT_BL) begin
        sw_clear[23:16] = ~sfr.wdata;
      end else if (sfr.addr == `PIC_ADR_LT_BH) begin
        sw_clear[31:24] = ~sfr.wdata;
      end else if (sfr.addr == `PIC_ADR_LT_C) begin
        sw_clear[38:32] = ~sfr.wdata[6:0];
      end
    end
  end

  always_comb begin
    en_wr_mask = '0;
    en_wr_val = '0;
    if (sfr.wr) begin
      if (sfr.addr == `PIC_ADR_EN_AL) begin
        en_wr_mask[7:0] = '1;
        en_wr_val[7:0] = sfr.wdata;
      end else if (sfr.addr == `PIC_ADR_EN_AH) begin
        en_wr_mask[15:8] = '1;
        en_wr_val[15:8] = sfr.wdata;
      end else if (sfr.addr == `PIC_ADR_EN_BL) begin
        en_wr_mask[23:16] = '1;
        en_wr_val[23:16] = sfr.wdata;
      end else if (sfr.addr == `PIC_ADR_EN_BH) begin
        en_wr_mask[31:24] = '1;
        en_wr_val[31:24] = sfr.wdata;
      end else if (sfr.addr == `PIC_ADR_EN_C) begin
        en_wr_mask[38:32] = '1;
        en_wr_val[38:32] = sfr.wdata[6:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source enable flags

  // Bits below the first maskable source do not exist
  assign source_enable_flag[`PIC_FIRST_ENABLE-1:0] = '0;

  generate
    for (genvar i = `PIC_FIRST_ENABLE; i < NPRIO; i++) begin : g_enable
      logic bit_reg;
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          bit_reg <= 1'b0;
        end else if (en_wr_mask[i]) begin
          bit_reg <= en_wr_val[i];
        end
      end
      assign source_enable_flag[i] = bit_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Master enable flag

  // acceptance clears it; returns and instructions
  always_comb begin
    master_next = master_reg;
    if (take) begin
      master_next = 1'b0;
    end else if (cpu.ret_mask) begin
      master_next = 1'b1;
    end else if (cpu.ret_pseudo) begin
      // Restores the value pushed at acceptance, so a handler that
      // cleared the flag in the stacked word keeps it clear
      master_next = cpu.popped_master;
    end else if (cpu.irq_on) begin
      master_next = 1'b1;
    end else if (cpu.irq_off) begin
      master_next = 1'b0;
    end else if (en_wr_mask[`PIC_MASTER_BIT]) begin
      master_next = en_wr_val[`PIC_MASTER_BIT];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      master_reg <= 1'b0;
    end else begin
      master_reg <= master_next;
    end
  end

  // value before clearing is handed out for the stack push
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      master_push_reg <= 1'b0;
    end else if (take) begin
      master_push_reg <= master_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance gating

  generate
    for (genvar i = 0; i < NPRIO; i++) begin : g_gate
      if (i == 0) begin : g_rst
        assign acceptable[i] = 1'b0;
      end else if (i == `PIC_PRIO_SWI) begin : g_swi
        // software and undefined share one slot, no order between them
        assign acceptable[i] = software_irq || undef_irq;
      end else if (i == `PIC_PRIO_WDT) begin : g_wdt
        assign acceptable[i] = request_latch[i];
      end else if (i == `PIC_PRIO_EXT0) begin : g_ext0
        assign acceptable[i] = request_latch[i] && master_reg
          && source_enable_flag[i] && ext0_input_enable;
      end else begin : g_mask
        assign acceptable[i] = request_latch[i] && master_reg && source_enable_flag[i];
      end
    end
  endgenerate

  // No source is masked here; the offer state machine holds every source back during the acceptance sequence
  assign pending = acceptable;

  pic_prio #(
    .NPRIO(NPRIO)
  ) u_prio (
    .acceptable(pending),
    .found(sel_found),
    .prio(sel_prio),
    .vector(sel_vector)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Machine cycle divider

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mc_cnt_reg <= '0;
    end else if (mc_tick) begin
      mc_cnt_reg <= '0;
    end else begin
      mc_cnt_reg <= mc_cnt_reg + MCW'(1);
    end
  end

  assign mc_tick = (mc_cnt_reg == MCW'(MC_CLKS - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Offer and acceptance sequence

  // offer made only at an instruction boundary; nesting allowed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= PIC_IDLE;
      irq_pending_reg <= 1'b0;
      irq_vector_reg <= '0;
      irq_prio_reg <= '0;
      seq_busy_reg <= 1'b0;
      seq_cnt_reg <= '0;
    end else begin
      case (state_reg)
        PIC_IDLE: begin
          if (cpu.boundary && sel_found) begin
            state_reg <= PIC_OFFER;
            irq_pending_reg <= 1'b1;
            irq_vector_reg <= sel_vector;
            irq_prio_reg <= sel_prio;
          end
        end
        PIC_OFFER: begin
          if (take) begin
            state_reg <= PIC_SEQ;
            irq_pending_reg <= 1'b0;
            seq_busy_reg <= 1'b1;
            seq_cnt_reg <= '0;
          end else if (cpu.boundary) begin
            // Re-evaluate so a withdrawn or outranked request is not offered
            irq_pending_reg <= sel_found;
            irq_vector_reg <= sel_vector;
            irq_prio_reg <= sel_prio;
            if (!sel_found) begin
              state_reg <= PIC_IDLE;
            end
          end
        end
        PIC_SEQ: begin
          if (mc_tick) begin
            if (seq_cnt_reg == SQW'(ACC_MC - 1)) begin
              state_reg <= PIC_IDLE;
              seq_busy_reg <= 1'b0;
            end else begin
              seq_cnt_reg <= seq_cnt_reg + SQW'(1);
            end
          end
        end
        default: begin
          state_reg <= PIC_IDLE;
        end
      endcase
    end
  end

  pic_nest #(
    .W(`PIC_NEST_W)
  ) u_nest (
    .clock(clock),
    .rst(rst),
    .up(take),
    .down(cpu.ret_mask || cpu.ret_pseudo),
    .count_reg(nesting_counter)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register reads

  // latches read back pending status; enables read back
  always_comb begin
    rd_next = '0;
    if (sfr.addr == `PIC_ADR_LT_AL) begin
      rd_next = request_latch[7:0];
    end else if (sfr.addr == `PIC_ADR_LT_AH) begin
      rd_next = request_latch[15:8];
    end else if (sfr.addr == `PIC_ADR_LT_BL) begin
      rd_next = request_latch[23:16];
    end else if (sfr.addr == `PIC_ADR_LT_BH) begin
      rd_next = request_latch[31:24];
    end else if (sfr.addr == `PIC_ADR_LT_C) begin
      rd_next = {1'b0, request_latch[38:32]};
    end else if (sfr.addr == `PIC_ADR_EN_AL) begin
      rd_next = {source_enable_flag[7:1], master_reg};
    end else if (sfr.addr == `PIC_ADR_EN_AH) begin
      rd_next = source_enable_flag[15:8];
    end else if (sfr.addr == `PIC_ADR_EN_BL) begin
      rd_next = source_enable_flag[23:16];
    end else if (sfr.addr == `PIC_ADR_EN_BH) begin
      rd_next = source_enable_flag[31:24];
    end else if (sfr.addr == `PIC_ADR_EN_C) begin
      rd_next = {1'b0, source_enable_flag[38:32]};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sfr_rdata_reg <= '0;
    end else if (sfr.rd) begin
      sfr_rdata_reg <= rd_next;
    end
  end

endmodule

// file: test/pic_top_props.sv
// Concurrent checks on the interrupt controller ports
`timescale 1ns/1ps
`include "pic_defs.svh"

module pic_top_props
  import pic_pkg::*;
#(
  parameter int NPRIO = `PIC_NPRIO,
  parameter int MC_CLKS = `PIC_MC_CLKS,
  parameter int ACC_MC = `PIC_ACC_MC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Inputs
  input wire pic_sfr_s sfr,
  input wire logic [7:0] sfr_rdata_reg,
  input wire pic_cpu_s cpu,
  input wire logic software_irq,
  input wire logic undef_irq,
  input wire logic [NPRIO-1:0] src_req,
  input wire logic ext0_input_enable,
  input wire logic watchdog_output_select,
  // Outputs
  input wire logic irq_pending_reg,
  input wire logic [`PIC_VEC_W-1:0] irq_vector_reg,
  input wire logic [`PIC_PRIO_W-1:0] irq_prio_reg,
  input wire logic seq_busy_reg,
  input wire logic master_enable_flag,
  input wire logic master_push_reg,
  input wire logic [`PIC_NEST_W-1:0] nesting_counter
);
  localparam int BUSY_HI = ACC_MC * MC_CLKS;
  localparam int BUSY_LO = BUSY_HI - MC_CLKS + 1;
  logic take;
  logic [7:0] busy_cnt_reg;
  logic [`PIC_VEC_W-1:0] exp_vec;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  assign take = irq_pending_reg && cpu.accept;
  // Two descending runs in steps of four, the second starting lower
  assign exp_vec = (irq_prio_reg < 6'h20 ? 20'hf_fffc : 20'hf_ffbc)
    - {12'h000, irq_prio_reg, 2'b00};
  // Divider phase makes the sequence length vary by less than one machine cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) busy_cnt_reg <= 8'h00;
    else if (seq_busy_reg) busy_cnt_reg <= busy_cnt_reg + 8'h01;
    else busy_cnt_reg <= 8'h00;
  end
  ////////////////////////////////////////
  chk_accept_masks: assert property (take |=>
    !master_enable_flag && seq_busy_reg && !irq_pending_reg) else $error("accept effects wrong");
  chk_push_value: assert property (take |=>
    master_push_reg == $past(master_enable_flag)) else $error("pushed flag wrong");
  chk_maskable_return_instr_sets: assert property (cpu.ret_mask && !take |=> master_enable_flag)
    else $error("return left flag clear");
  chk_pseudo_nmi_return_instr_restore: assert property (cpu.ret_pseudo && !cpu.ret_mask && !take |=>
    master_enable_flag == $past(cpu.popped_master)) else $error("flag not restored");
  chk_di_clears: assert property (cpu.irq_off
    && !(cpu.irq_on || cpu.ret_mask || cpu.ret_pseudo || take)
    |=> !master_enable_flag) else $error("mask instruction ignored");
  chk_vector_map: assert property (irq_pending_reg |-> irq_vector_reg == exp_vec)
    else $error("vector wrong");
  chk_busy_span: assert property ($fell(seq_busy_reg) |->
    busy_cnt_reg >= BUSY_LO && busy_cnt_reg <= BUSY_HI) else $error("sequence length wrong");
  chk_nest_up: assert property (take && !cpu.ret_mask && !cpu.ret_pseudo
    && nesting_counter != 2'h3 |=> nesting_counter == $past(nesting_counter) + 2'h1)
    else $error("depth not counted");
  chk_offer_boundary: assert property ($rose(irq_pending_reg) |-> $past(cpu.boundary))
    else $error("offer off boundary");
endmodule

bind pic_top pic_top_props #(.NPRIO(NPRIO), .MC_CLKS(MC_CLKS), .ACC_MC(ACC_MC)) u_pic_top_props (
  .clock, .rst, .sfr, .sfr_rdata_reg, .cpu, .software_irq, .undef_irq, .src_req,
  .ext0_input_enable, .watchdog_output_select, .irq_pending_reg, .irq_vector_reg,
  .irq_prio_reg, .seq_busy_reg, .master_enable_flag, .master_push_reg, .nesting_counter);

// file: test/pic_cpu_model.sv
// CPU core stand-in: instruction boundaries and acceptance handshake
`timescale 1ns/1ps

module pic_cpu_model (
  // Clock
  input wire logic clock,
  // Offer from the controller
  input wire logic irq_pending_reg,
  input wire logic seq_busy_reg,
  // Pace, high for slow
  input wire logic slow,
  // Handshake
  output logic boundary,
  output logic accept
);
  logic [3:0] gap_reg;
  logic [1:0] wait_reg;

  initial begin
    boundary = 1'b0;
    accept = 1'b0;
    gap_reg = 4'h0;
    wait_reg = 2'h0;
  end
  // No instruction ends while the acceptance sequence runs
  always @(negedge clock) begin
    gap_reg <= (gap_reg == 4'h0) ? (slow ? 4'h9 : 4'h3) : gap_reg - 4'h1;
    boundary <= (gap_reg == 4'h0) && !seq_busy_reg;
  end
  // Slow pace answers an offer late, so the offer must stand meanwhile
  always @(negedge clock) begin
    wait_reg <= (irq_pending_reg && !accept) ? wait_reg + 2'h1 : 2'h0;
    accept <= irq_pending_reg && !accept && (!slow || wait_reg == 2'h2);
  end
endmodule

// file: test/pic_top_bench.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`include "pic_defs.svh"

module pic_top_bench
  import pic_pkg::*;
;
  localparam logic [3:0] EV_ON = 4'h8, EV_OFF = 4'h4, EV_RETM = 4'h2, EV_RETP = 4'h1;
  logic clock = 1'b0;
  logic rst = 1'b1;
  pic_sfr_s sfr = '0;
  pic_cpu_s cpu;
  logic [3:0] cev = 4'h0;
  logic software_irq = 1'b0;
  logic [`PIC_NPRIO-1:0] src_req = '0;
  logic ext0_en = 1'b1;
  logic wos = 1'b0;
  logic slow = 1'b0;
  logic bnd, acc, pend, busy, mflag, push;
  logic [7:0] rdata;
  logic [19:0] vec;
  logic [5:0] prio;
  logic [1:0] nest;
  int n_fail = 0;
  int n_tests = 0;
  logic [5:0] row_prio [8] = '{6'h01, 6'h02, 6'h03, 6'h05, 6'h0f, 6'h1f, 6'h20, 6'h26};
  logic [19:0] row_vec [8] = '{20'hf_fff8, 20'hf_fff4, 20'hf_fff0, 20'hf_ffe8, 20'hf_ffc0,
    20'hf_ff80, 20'hf_ff3c, 20'hf_ff24};
  logic [7:0] adrs [10] = '{8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h3a, 8'h3b, 8'h3c,
    8'h3d};

  // The core pops back the flag that it pushed at the last acceptance
  assign cpu = {bnd, acc, cev, push};
  always #4 clock = ~clock;

  pic_top #(.ACC_MC(2)) u_pic_top (.clock(clock), .rst(rst), .sfr(sfr), .sfr_rdata_reg(rdata),
    .cpu(cpu), .software_irq(software_irq), .undef_irq(1'b0), .src_req(src_req),
    .ext0_input_enable(ext0_en), .watchdog_output_select(wos), .irq_pending_reg(pend),
    .irq_vector_reg(vec), .irq_prio_reg(prio), .seq_busy_reg(busy),
    .master_enable_flag(mflag), .master_push_reg(push), .nesting_counter(nest));
  pic_cpu_model u_pic_cpu_model (.clock(clock), .irq_pending_reg(pend), .seq_busy_reg(busy),
    .slow(slow), .boundary(bnd), .accept(acc));
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Strobes drop after one edge, then one idle cycle keeps calls apart
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    tick(1);
    sfr.wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    tick(1);
    sfr.rd = 1'b0;
    tick(1);
    check("read data", rdata, exp);
  endtask
  task automatic ev(input logic [3:0] e);
    cev = e;
    tick(1);
    cev = 4'h0;
    tick(1);
  endtask
  task automatic req(input int p);
    src_req[p] = 1'b1;
    tick(1);
    src_req = '0;
    tick(1);
  endtask
  task automatic offer(input logic [5:0] p);
    int i;
    for (i = 0; i < 60 && pend !== 1'b1; i++) tick(1);
    check("offered priority", {pend, prio}, {1'b1, p});
  endtask
  task automatic idle;
    int i;
    for (i = 0; i < 20 && busy !== 1'b1; i++) tick(1);
    for (i = 0; i < 80 && busy !== 1'b0; i++) tick(1);
  endtask
  function automatic logic [7:0] ad(input int p, input logic lt);
    logic [7:0] b;
    b = p < 8 ? 8'h3a : p < 16 ? 8'h3b : p < 24 ? 8'h2c : p < 32 ? 8'h2d : 8'h2a;
    return b + (lt ? (b > 8'h2b ? 8'h02 : 8'h01) : 8'h00);
  endfunction
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    int r;
    int p;
    tick(5);
    rst = 1'b0;
    // Pseudo non-maskable rows run with the master flag off
    for (r = 0; r < 8; r++) begin
      p = row_prio[r];
      ev(EV_OFF);
      if (p >= 3) begin
        wr(ad(p, 1'b0), 8'h01 << (p % 8));
        ev(EV_ON);
      end
      if (p == 1) software_irq = 1'b1;
      else req(p);
      offer(row_prio[r]);
      check("vector", vec, row_vec[r]);
      tick(1);
      software_irq = 1'b0;
      idle();
      rd(ad(p, 1'b1), 8'h00);
      ev(p < 3 ? EV_RETP : EV_RETM);
      check("flag after return", mflag, p >= 3);
      check("depth", nest, 2'h0);
    end
    slow = 1'b1;
    ev(EV_OFF);
    wr(8'h2a, 8'h40);
    wr(8'h3b, 8'h10);
    wr(8'h3a, 8'h20);
    src_req[38] = 1'b1;
    src_req[12] = 1'b1;
    tick(1);
    src_req = '0;
    tick(12);
    check("held off", pend, 1'b0);
    ev(EV_ON);
    offer(6'h0c);
    idle();
    req(5);
    ev(EV_ON);
    offer(6'h05);
    idle();
    check("depth", nest, 2'h2);
    ev(EV_RETM);
    offer(6'h26);
    idle();
    ev(EV_RETM);
    ev(EV_RETM);
    check("depth", nest, 2'h0);
    slow = 1'b0;
    ev(EV_OFF);
    wr(8'h3a, 8'h00);
    req(6);
    rd(8'h3c, 8'h40);
    wr(8'h3c, 8'hff);
    rd(8'h3c, 8'h40);
    wr(8'h3c, 8'hbf);
    rd(8'h3c, 8'h00);
    src_req[6] = 1'b1;
    sfr = '{rd: 1'b0, wr: 1'b1, addr: 8'h3c, wdata: 8'hbf};
    tick(1);
    src_req = '0;
    sfr.wr = 1'b0;
    tick(1);
    rd(8'h3c, 8'h40);
    wr(8'h3c, 8'hbf);
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h00);
    ext0_en = 1'b0;
    wr(8'h3a, 8'h08);
    ev(EV_ON);
    rd(8'h3a, 8'h09);
    req(3);
    tick(15);
    check("ext0 gated", pend, 1'b0);
    ext0_en = 1'b1;
    offer(6'h03);
    idle();
    ev(EV_RETM);
    // Pseudo non-maskable taken with the master flag on must restore it
    software_irq = 1'b1;
    offer(6'h01);
    tick(1);
    software_irq = 1'b0;
    check("pushed flag", push, 1'b1);
    idle();
    ev(EV_RETP);
    check("flag after return", mflag, 1'b1);
    check("depth", nest, 2'h0);
    wos = 1'b1;
    ev(EV_OFF);
    req(2);
    rd(8'h3c, 8'h00);
    wr(8'h2a, 8'hff);
    rd(8'h2a, 8'h7f);
    req(6);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    for (r = 0; r < 10; r++) rd(adrs[r], 8'h00);
    check("flag after reset", mflag, 1'b0);
    conclude();
  end
  initial begin
    #50000;
    n_fail++;
    conclude();
  end
endmodule
